// ===== shared/branch_control_io_decode_pkg.sv
// constants and types for the branch, control and i/o decoder
package branch_control_io_decode_pkg;
  localparam logic [15:0] OP_BR_AUX_NZ = 16'hf400;
  localparam logic [15:0] OP_BR_GE = 16'hfd00;
  localparam logic [15:0] OP_BR_GT = 16'hfc00;
  localparam logic [15:0] OP_BR_IO = 16'hf600;
  localparam logic [15:0] OP_BR_NEG = 16'hfa00;
  localparam logic [15:0] OP_BR_NZ = 16'hfe00;
  localparam logic [15:0] OP_BR_Z = 16'hff00;
  localparam logic [15:0] OP_POP = 16'h7f9d;
  localparam logic [15:0] OP_PUSH = 16'h7f9c;
  localparam logic [7:0] OP_LOAD_STATUS = 8'h7b;
  localparam logic [7:0] OP_DATA_SHIFT = 8'h69;
  localparam logic [4:0] OP_PORT_IN = 5'h08;
  localparam logic [3:0] TARGET_TOP = 4'h0;
  localparam int TARGET_W = 12;
  localparam int INDIRECT_BIT = 7;
  localparam int MEM_FIELD_W = 7;
  localparam int PORT_LSB = 8;
  localparam int PORT_W = 3;
  localparam int BRANCH_CYCLES = 2;
  localparam int STACK_CYCLES = 2;
  localparam int PORT_IN_CYCLES = 2;
  localparam logic [TARGET_W-1:0] RST_TARGET = 12'h000;
  localparam logic [MEM_FIELD_W-1:0] RST_MEM_FIELD = 7'h00;
  localparam logic [PORT_W-1:0] RST_PORT = 3'h0;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_TARGET = 3'b010,
    ST_HOLD = 3'b100
  } state_e;

  typedef enum logic [2:0] {
    C_AUX_NZ = 3'h0,
    C_GE = 3'h1,
    C_GT = 3'h2,
    C_IO_LOW = 3'h3,
    C_NEG = 3'h4,
    C_NZ = 3'h5,
    C_Z = 3'h6
  } cond_e;
endpackage

// ===== hdl/branch_control_io_decode.sv
// decoder and sequencer for branch, stack, status, move and port-in words
`timescale 1ns/1ps
module branch_control_io_decode (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] acc,
  input wire logic [15:0] aux_value,
  input wire logic io_status,
  output logic word_ready,
  output logic branch_done,
  output logic branch_taken,
  output logic [11:0] branch_target,
  output logic stack_push,
  output logic stack_pop,
  output logic load_status_word,
  output logic data_word_shift,
  output logic port_read,
  output logic [2:0] port_sel,
  output logic mem_indirect,
  output logic [6:0] mem_field,
  output logic foreign_op
);

  // returns {hit, condition} for a first branch word
  function automatic logic [3:0] branch_code(input logic [15:0] w);
    logic [3:0] r;
    r = 4'h0;
    if (w == branch_control_io_decode_pkg::OP_BR_AUX_NZ) begin
      r = {1'b1, branch_control_io_decode_pkg::C_AUX_NZ};
    end else if (w == branch_control_io_decode_pkg::OP_BR_GE) begin
      r = {1'b1, branch_control_io_decode_pkg::C_GE};
    end else if (w == branch_control_io_decode_pkg::OP_BR_GT) begin
      r = {1'b1, branch_control_io_decode_pkg::C_GT};
    end else if (w == branch_control_io_decode_pkg::OP_BR_IO) begin
      r = {1'b1, branch_control_io_decode_pkg::C_IO_LOW};
    end else if (w == branch_control_io_decode_pkg::OP_BR_NEG) begin
      r = {1'b1, branch_control_io_decode_pkg::C_NEG};
    end else if (w == branch_control_io_decode_pkg::OP_BR_NZ) begin
      r = {1'b1, branch_control_io_decode_pkg::C_NZ};
    end else if (w == branch_control_io_decode_pkg::OP_BR_Z) begin
      r = {1'b1, branch_control_io_decode_pkg::C_Z};
    end
    return r;
  endfunction

  function automatic logic cond_met(
    input branch_control_io_decode_pkg::cond_e c,
    input logic [31:0] a,
    input logic [15:0] x,
    input logic io
  );
    logic m;
    m = 1'b0;
    case (c)
      branch_control_io_decode_pkg::C_AUX_NZ: m = (x != 16'h0000);
      branch_control_io_decode_pkg::C_GE: m = !a[31];
      branch_control_io_decode_pkg::C_GT: m = !a[31] && (a != 32'h0000_0000);
      branch_control_io_decode_pkg::C_IO_LOW: m = !io;
      branch_control_io_decode_pkg::C_NEG: m = a[31];
      branch_control_io_decode_pkg::C_NZ: m = (a != 32'h0000_0000);
      branch_control_io_decode_pkg::C_Z: m = (a == 32'h0000_0000);
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  branch_control_io_decode_pkg::state_e state_q, state_d;
  branch_control_io_decode_pkg::cond_e cond_q, cond_d;
  logic [1:0] hold_q, hold_d;
  logic io_meta_q, io_meta_d;
  logic io_sync_q, io_sync_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic taken_q, taken_d;
  logic [11:0] target_q, target_d;
  logic push_q, push_d;
  logic pop_q, pop_d;
  logic status_q, status_d;
  logic shift_q, shift_d;
  logic port_q, port_d;
  logic [2:0] port_sel_q, port_sel_d;
  logic indirect_q, indirect_d;
  logic [6:0] field_q, field_d;
  logic foreign_q, foreign_d;
  logic [3:0] bcode;
  logic take_first;
  logic take_target;
  logic hit_status;
  logic hit_pop;
  logic hit_push;
  logic hit_shift;
  logic hit_port;

  // io status is a pin: two flops before the condition logic
  always_comb begin
    io_meta_d = io_status;
    io_sync_d = io_meta_q;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      io_meta_q <= 1'b1;
      io_sync_q <= 1'b1;
    end else begin
      io_meta_q <= io_meta_d;
      io_sync_q <= io_sync_d;
    end
  end

  // word decode shared by every group; branch, pop and push words match in full, others by prefix
  // fetch and target states always have ready high, so valid alone takes a word
  always_comb begin
    bcode = branch_code(instr_word);
    take_first = instr_valid && (state_q == branch_control_io_decode_pkg::ST_FETCH);
    take_target = instr_valid && (state_q == branch_control_io_decode_pkg::ST_TARGET);
    hit_status = 1'b0;
    hit_pop = 1'b0;
    hit_push = 1'b0;
    hit_shift = 1'b0;
    hit_port = 1'b0;
    if (!bcode[3]) begin
      if (instr_word[15:8] == branch_control_io_decode_pkg::OP_LOAD_STATUS) begin
        hit_status = 1'b1;
      end else if (instr_word == branch_control_io_decode_pkg::OP_POP) begin
        hit_pop = 1'b1;
      end else if (instr_word == branch_control_io_decode_pkg::OP_PUSH) begin
        hit_push = 1'b1;
      end else if (instr_word[15:8] == branch_control_io_decode_pkg::OP_DATA_SHIFT) begin
        hit_shift = 1'b1;
      end else if (instr_word[15:11] == branch_control_io_decode_pkg::OP_PORT_IN) begin
        hit_port = 1'b1;
      end
    end
  end

  // sequencer: fetch, wait for the target word, or stall a one-word two-cycle op
  always_comb begin
    state_d = state_q;
    cond_d = cond_q;
    hold_d = hold_q;
    case (state_q)
      branch_control_io_decode_pkg::ST_FETCH: begin
        if (take_first && bcode[3]) begin
          cond_d = branch_control_io_decode_pkg::cond_e'(bcode[2:0]);
          state_d = branch_control_io_decode_pkg::ST_TARGET;
        end else if (take_first && hit_pop) begin
          // stall counted from the cycle figure, the word count stays one
          hold_d = 2'(branch_control_io_decode_pkg::STACK_CYCLES - 2);
          state_d = branch_control_io_decode_pkg::ST_HOLD;
        end else if (take_first && hit_push) begin
          hold_d = 2'(branch_control_io_decode_pkg::STACK_CYCLES - 2);
          state_d = branch_control_io_decode_pkg::ST_HOLD;
        end else if (take_first && hit_port) begin
          hold_d = 2'(branch_control_io_decode_pkg::PORT_IN_CYCLES - 2);
          state_d = branch_control_io_decode_pkg::ST_HOLD;
        end
      end
      branch_control_io_decode_pkg::ST_TARGET: begin
        // waits here however long program memory delays the target word
        if (take_target) begin
          state_d = branch_control_io_decode_pkg::ST_FETCH;
        end
      end
      branch_control_io_decode_pkg::ST_HOLD: begin
        // no word is taken while the stall runs down
        if (hold_q == 2'h0) begin
          state_d = branch_control_io_decode_pkg::ST_FETCH;
        end else begin
          hold_d = hold_q - 2'h1;
        end
      end
      default: begin
        state_d = branch_control_io_decode_pkg::ST_FETCH;
      end
    endcase
    ready_d = (state_d != branch_control_io_decode_pkg::ST_HOLD);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= branch_control_io_decode_pkg::ST_FETCH;
      cond_q <= branch_control_io_decode_pkg::C_AUX_NZ;
      hold_q <= 2'h0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cond_q <= cond_d;
      hold_q <= hold_d;
      ready_q <= ready_d;
    end
  end

  // one-cycle strobes to the datapath, a cycle after the deciding word
  always_comb begin
    done_d = take_target;
    status_d = take_first && hit_status;
    pop_d = take_first && hit_pop;
    push_d = take_first && hit_push;
    shift_d = take_first && hit_shift;
    port_d = take_first && hit_port;
    // another unit's opcode; flagged so a decode gap shows up
    foreign_d = take_first && !bcode[3] && !(hit_status || hit_pop || hit_push || hit_shift
      || hit_port);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      status_q <= 1'b0;
      shift_q <= 1'b0;
      port_q <= 1'b0;
      foreign_q <= 1'b0;
    end else begin
      done_q <= done_d;
      push_q <= push_d;
      pop_q <= pop_d;
      status_q <= status_d;
      shift_q <= shift_d;
      port_q <= port_d;
      foreign_q <= foreign_d;
    end
  end

  // condition sampled with the second word so the acc has settled
  always_comb begin
    taken_d = 1'b0;
    target_d = target_q;
    if (take_target) begin
      taken_d = cond_met(cond_q, acc, aux_value, io_sync_q);
      target_d = instr_word[branch_control_io_decode_pkg::TARGET_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      taken_q <= 1'b0;
      target_q <= branch_control_io_decode_pkg::RST_TARGET;
    end else begin
      taken_q <= taken_d;
      target_q <= target_d;
    end
  end

  // fields latched for every first word; only memory ops use them downstream
  // port number held until the next port read, so it can be decoded late
  always_comb begin
    indirect_d = indirect_q;
    field_d = field_q;
    port_sel_d = port_sel_q;
    if (take_first) begin
      indirect_d = instr_word[branch_control_io_decode_pkg::INDIRECT_BIT];
      field_d = instr_word[branch_control_io_decode_pkg::MEM_FIELD_W-1:0];
    end
    if (take_first && hit_port) begin
      port_sel_d = instr_word[branch_control_io_decode_pkg::PORT_LSB +:
        branch_control_io_decode_pkg::PORT_W];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      indirect_q <= 1'b0;
      field_q <= branch_control_io_decode_pkg::RST_MEM_FIELD;
      port_sel_q <= branch_control_io_decode_pkg::RST_PORT;
    end else begin
      indirect_q <= indirect_d;
      field_q <= field_d;
      port_sel_q <= port_sel_d;
    end
  end

  assign word_ready = ready_q;
  assign branch_done = done_q;
  assign branch_taken = taken_q;
  assign branch_target = target_q;
  assign stack_push = push_q;
  assign stack_pop = pop_q;
  assign load_status_word = status_q;
  assign data_word_shift = shift_q;
  assign port_read = port_q;
  assign port_sel = port_sel_q;
  assign mem_indirect = indirect_q;
  assign mem_field = field_q;
  assign foreign_op = foreign_q;

endmodule // branch_control_io_decode

// ===== testbench/branch_control_io_decode_monitor.sv
// port assertions for the decoder
`timescale 1ns/1ps
module branch_control_io_decode_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic word_ready,
  input wire logic branch_done,
  input wire logic [11:0] branch_target,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic load_status_word,
  input wire logic data_word_shift,
  input wire logic port_read,
  input wire logic [2:0] port_sel,
  input wire logic mem_indirect,
  input wire logic [6:0] mem_field
);
  logic tgt_q;
  logic tgt_d;
  logic first;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // tracks the target-word wait so opcode words are told apart
  assign first = instr_valid && word_ready && !tgt_q;
  always_comb begin
    tgt_d = tgt_q ? !(instr_valid && word_ready) : first && instr_word inside
      {16'hf400, 16'hfd00, 16'hfc00, 16'hf600, 16'hfa00, 16'hfe00, 16'hff00};
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tgt_q <= 1'b0;
    end else begin
      tgt_q <= tgt_d;
    end
  end
  property p_pop; first && instr_word == 16'h7f9d |=> stack_pop && !word_ready ##1 word_ready;
  endproperty
  a_pop: assert property (p_pop) else $error("pop timing");
  property p_push; first && instr_word == 16'h7f9c |=> stack_push && !word_ready ##1 word_ready;
  endproperty
  a_push: assert property (p_push) else $error("push timing");
  property p_port; first && instr_word[15:11] == 5'h08 |=> port_read && !word_ready
    && port_sel == $past(instr_word[10:8]) ##1 word_ready; endproperty
  a_port: assert property (p_port) else $error("port read");
  property p_lsw; first && instr_word[15:8] == 8'h7b |=> load_status_word && word_ready;
  endproperty
  a_lsw: assert property (p_lsw) else $error("status load");
  property p_shift; first && instr_word[15:8] == 8'h69 |=> data_word_shift && word_ready;
  endproperty
  a_shift: assert property (p_shift) else $error("data shift");
  property p_mem; first |=> {mem_indirect, mem_field} == $past(instr_word[7:0]); endproperty
  a_mem: assert property (p_mem) else $error("address field");
  property p_br; tgt_q && instr_valid |-> word_ready ##1 branch_done
    && branch_target == $past(instr_word[11:0]); endproperty
  a_br: assert property (p_br) else $error("branch end");
  property p_early; first |=> !branch_done; endproperty
  a_early: assert property (p_early) else $error("branch too short");
endmodule // branch_control_io_decode_monitor
bind branch_control_io_decode branch_control_io_decode_monitor monitor_inst (.mclk, .reset_n,
  .instr_valid, .instr_word, .word_ready, .branch_done, .branch_target, .stack_push,
  .stack_pop, .load_status_word, .data_word_shift, .port_read, .port_sel, .mem_indirect,
  .mem_field);

// ===== testbench/prog_mem_model.sv
// program memory model handing out queued instruction words
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic mclk,
  input wire logic word_ready,
  output logic instr_valid,
  output logic [15:0] instr_word
);
  logic [15:0] q[$];
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
  end
  task automatic put(input logic [15:0] w);
    q.push_back(w);
  endtask
  // word held until taken; random gaps stretch branch pairs
  always @(posedge mclk) begin
    if (instr_valid && word_ready) void'(q.pop_front());
    if (!instr_valid || word_ready) begin
      if (q.size() > 0 && $urandom_range(3, 0) != 0) begin
        instr_valid <= 1'b1;
        instr_word <= q[0];
      end else begin
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
      end
    end
  end
endmodule // prog_mem_model

// ===== testbench/branch_control_io_decode_tb.sv
// random and corner-case bench for the decoder
`timescale 1ns/1ps
module branch_control_io_decode_tb;
  logic mclk, reset_n, io_status, instr_valid, word_ready, branch_done, branch_taken;
  logic stack_push, stack_pop, load_status_word, data_word_shift, port_read, foreign_op;
  logic mem_indirect;
  logic [31:0] acc;
  logic [15:0] aux_value, instr_word;
  logic [11:0] branch_target;
  logic [6:0] mem_field;
  logic [2:0] port_sel;
  logic [19:0] exp_q[$];
  int fails, n_compared;
  logic [31:0] corner[5] = '{32'h0, 32'h1, 32'hffffffff, 32'h80000000, 32'h7fffffff};
  logic [15:0] ops[13] = '{16'hf400, 16'hfd00, 16'hfc00, 16'hf600, 16'hfa00, 16'hfe00,
    16'hff00, 16'h7f9c, 16'h7f9d, 16'h7b00, 16'h6900, 16'h4000, 16'h0000};
  logic [15:0] fld[13] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h00ff, 16'h00ff, 16'h07ff, 16'hffff};
  branch_control_io_decode branch_control_io_decode_inst (.mclk, .reset_n, .instr_valid,
    .instr_word, .acc, .aux_value, .io_status, .word_ready, .branch_done, .branch_taken,
    .branch_target, .stack_push, .stack_pop, .load_status_word, .data_word_shift, .port_read,
    .port_sel, .mem_indirect, .mem_field, .foreign_op);
  prog_mem_model prog_mem_model_inst (.mclk, .word_ready, .instr_valid, .instr_word);
  always #2.5 mclk = ~mclk;
  function automatic logic is_br(input logic [15:0] w);
    return w inside {16'hf400, 16'hfd00, 16'hfc00, 16'hf600, 16'hfa00, 16'hfe00, 16'hff00};
  endfunction
  // packs pulses, then taken and target, or port and address field
  function automatic logic [19:0] expect_of(input logic [15:0] w, input logic [15:0] t);
    logic c;
    case (w)
      16'hf400: c = aux_value != 16'h0000;
      16'hfd00: c = !acc[31];
      16'hfc00: c = !acc[31] && acc != 32'h0;
      16'hf600: c = !io_status;
      16'hfa00: c = acc[31];
      16'hfe00: c = acc != 32'h0;
      default: c = acc == 32'h0;
    endcase
    if (is_br(w)) return {7'h01, c, t[11:0]};
    if (w == 16'h7f9c) return {7'h40, 5'h00, w[7:0]};
    if (w == 16'h7f9d) return {7'h20, 5'h00, w[7:0]};
    if (w[15:8] == 8'h7b) return {7'h10, 5'h00, w[7:0]};
    if (w[15:8] == 8'h69) return {7'h08, 5'h00, w[7:0]};
    if (w[15:11] == 5'h08) return {7'h04, 2'h0, w[10:8], w[7:0]};
    return {7'h02, 5'h00, w[7:0]};
  endfunction
  task automatic check(input logic [19:0] got, input logic [19:0] want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge mclk) begin
    logic [6:0] p;
    p = {stack_push, stack_pop, load_status_word, data_word_shift, port_read, foreign_op,
      branch_done};
    if (reset_n && p != 7'h00) check({p, branch_done ? {branch_taken, branch_target} :
      {2'h0, port_read ? port_sel : 3'h0, mem_indirect, mem_field}},
      exp_q.size() > 0 ? exp_q.pop_front() : 20'hfffff);
  end
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    test_done;
  end
  initial begin
    logic [15:0] w;
    logic [15:0] t;
    int k;
    mclk = 1'b0;
    reset_n = 1'b0;
    acc = 32'h0;
    aux_value = 16'h0;
    io_status = 1'b1;
    fails = 0;
    n_compared = 0;
    void'($urandom(93287));
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int b = 0; b < 60; b++) begin
      @(posedge mclk);
      acc <= b < 5 ? corner[b] : $urandom;
      aux_value <= $urandom_range(1, 0) ? 16'h0000 : 16'($urandom);
      io_status <= 1'($urandom);
      // synchroniser on the status pin needs a few cycles
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
        k = $urandom_range(12, 0);
        w = ops[k] | (16'($urandom) & fld[k]);
        t = 16'($urandom);
        prog_mem_model_inst.put(w);
        if (is_br(w)) prog_mem_model_inst.put(t);
        exp_q.push_back(expect_of(w, t));
      end
      for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(posedge mclk);
    end
    check(20'(exp_q.size()), 20'h0);
    test_done;
  end
endmodule // branch_control_io_decode_tb
